//--- hdl/ofs_pkg.sv
// constants and types shared by the overcurrent fault sequencer
package ofs_pkg;

  // =========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned RETRY_WAIT_MS   = 12;
  localparam int unsigned RETRY_WAIT_CYC  = (CLK_HZ / 1000) * RETRY_WAIT_MS;

  // =========================================================================
  // retry accounting
  localparam int unsigned MAX_ATTEMPTS    = 7;
  localparam logic [2:0]  ATTEMPT_RST     = 3'h0;

  // =========================================================================
  // apb register map
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  STAT_OFS        = 8'h04;
  localparam logic [7:0]  ATTEMPT_OFS     = 8'h08;
  localparam int unsigned CTRL_EN_BIT     = 0;
  localparam int unsigned CTRL_NB_EN_BIT  = 1;
  localparam int unsigned CTRL_PSI_BIT    = 2;
  localparam logic [2:0]  CTRL_RST        = 3'h0;

  // =========================================================================
  // sequencer states
  typedef enum logic [2:0] {
    OFS_OFF      = 3'b000,
    OFS_SOFT     = 3'b001,
    OFS_RUN      = 3'b010,
    OFS_WAIT     = 3'b011,
    OFS_LATCHED  = 3'b100,
    OFS_OPEN     = 3'b101
  } ofs_state_t;

endpackage : ofs_pkg

//--- hdl/ofs_sync.sv
// three-stage synchroniser for a bus of asynchronous comparator flags
`timescale 1ns/10ps
module ofs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ofs_sync_st_t;

  ofs_sync_st_t st_q;
  ofs_sync_st_t st_d;

  // =========================================================================
  // stage logic: a change counts once stages two and three agree
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.q[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.q;

endmodule // ofs_sync

//--- hdl/ofs_chan_limit.sv
// per-channel cycle-by-cycle current limiter for the core phases
`timescale 1ns/10ps
module ofs_chan_limit #(
  parameter int unsigned NCH = 4
) (
  input  wire logic           clk_sys,
  input  wire logic           rst_b,
  input  wire logic [NCH-1:0] pwm_upper_req,
  input  wire logic [NCH-1:0] pwm_lower_req,
  input  wire logic [NCH-1:0] chan_over_limit,
  output logic      [NCH-1:0] upper_lim,
  output logic      [NCH-1:0] lower_lim,
  output logic      [NCH-1:0] limit_active
);

  typedef struct packed {
    logic [NCH-1:0] act;
  } ofs_cl_st_t;

  ofs_cl_st_t st_q;
  ofs_cl_st_t st_d;

  // =========================================================================
  // per channel limiting
  always_comb begin
    st_d     = st_q;
    st_d.act = chan_over_limit;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign upper_lim[g] = pwm_upper_req[g] & ~chan_over_limit[g];
      assign lower_lim[g] = pwm_lower_req[g] | chan_over_limit[g];
    end
  endgenerate

  assign limit_active = st_q.act;

endmodule // ofs_chan_limit

//--- hdl/ofs_top.sv
// overcurrent and open-sense fault sequencer with apb status and control
`timescale 1ns/10ps
module ofs_top
  import ofs_pkg::*;
#(
  parameter int unsigned NCH            = 4,
  parameter int unsigned RETRY_WAIT_CNT = RETRY_WAIT_CYC
) (
  input  wire logic           clk_sys,
  input  wire logic           rst_b,
  // apb slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // asynchronous comparator flags and status
  input  wire logic           sense_open,
  input  wire logic           core_avg_over_nom,
  input  wire logic           core_avg_over_boost,
  input  wire logic           nb_avg_over_nom,
  input  wire logic           nb_avg_over_boost,
  input  wire logic [NCH-1:0] chan_over_limit,
  input  wire logic           soft_start_done,
  input  wire logic           nb_soft_start_done,
  input  wire logic           volts_in_limits,
  // modulator requests
  input  wire logic [NCH-1:0] pwm_upper_req,
  input  wire logic [NCH-1:0] pwm_lower_req,
  input  wire logic           nb_upper_req,
  input  wire logic           nb_lower_req,
  // power-stage commands
  output logic [1:0]          upper_gate_drive,
  output logic [1:0]          lower_gate_drive,
  output logic                nb_upper_gate_drive,
  output logic                nb_lower_gate_drive,
  output logic                external_phase_three_drive,
  output logic                external_phase_three_oe_b,
  output logic                external_phase_four_drive,
  output logic                external_phase_four_oe_b,
  output logic                power_good_out,
  output logic                power_save_indicator,
  output logic                core_soft_start_req,
  output logic                nb_soft_start_req
);

  localparam int unsigned NFLAG = 8 + NCH;

  typedef struct packed {
    ofs_state_t  core_st;
    ofs_state_t  nb_st;
    logic [31:0] core_wait;
    logic [31:0] nb_wait;
    logic [2:0]  core_att;
    logic [2:0]  nb_att;
    logic        latched;
    logic [2:0]  ctrl;
    logic        pg;
    logic        psi;
    logic [31:0] rdata;
  } ofs_st_t;

  ofs_st_t st_q;
  ofs_st_t st_d;

  logic [NFLAG-1:0] flag_sync;
  logic             s_open;
  logic             s_core_nom;
  logic             s_core_bst;
  logic             s_nb_nom;
  logic             s_nb_bst;
  logic [NCH-1:0]   s_chan;
  logic             s_ss_done;
  logic             s_nb_ss_done;
  logic             s_vok;
  logic [NCH-1:0]   ch_upper;
  logic [NCH-1:0]   ch_lower;
  logic [NCH-1:0]   ch_lim_act;
  logic             en;
  logic             nb_en;
  logic             core_trip;
  logic             nb_trip;
  logic             apb_wr;
  logic             apb_rd;
  logic             core_on;
  logic             nb_on;

  // =========================================================================
  // input synchronisation
  // sync comparator flags
  ofs_sync #(
    .W (NFLAG)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in ({sense_open, core_avg_over_nom, core_avg_over_boost, nb_avg_over_nom,
                nb_avg_over_boost, chan_over_limit, soft_start_done,
                nb_soft_start_done, volts_in_limits}),
    .sync_out (flag_sync)
  );

  assign {s_open, s_core_nom, s_core_bst, s_nb_nom, s_nb_bst, s_chan,
          s_ss_done, s_nb_ss_done, s_vok} = flag_sync;

  // =========================================================================
  // channel limiter
  ofs_chan_limit #(
    .NCH (NCH)
  ) u_lim (
    .clk_sys         (clk_sys),
    .rst_b           (rst_b),
    .pwm_upper_req   (pwm_upper_req),
    .pwm_lower_req   (pwm_lower_req),
    .chan_over_limit (s_chan),
    .upper_lim       (ch_upper),
    .lower_lim       (ch_lower),
    .limit_active    (ch_lim_act)
  );

  assign en     = st_q.ctrl[CTRL_EN_BIT];
  assign nb_en  = st_q.ctrl[CTRL_NB_EN_BIT];
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~pwrite;

  assign core_trip = (st_q.core_st == OFS_SOFT) ? s_core_bst :
                     (st_q.core_st == OFS_RUN)  ? s_core_nom : 1'b0;
  assign nb_trip   = (st_q.nb_st == OFS_SOFT) ? s_nb_bst :
                     (st_q.nb_st == OFS_RUN)  ? s_nb_nom : 1'b0;

  // =========================================================================
  // sequencer
  always_comb begin
    st_d = st_q;
    // apb control register
    if (apb_wr && paddr == CTRL_OFS) begin
      st_d.ctrl = pwdata[2:0];
    end
    st_d.rdata = 32'h0;
    if (apb_rd) begin
      case (paddr)
        CTRL_OFS:    st_d.rdata = {29'h0, st_q.ctrl};
        STAT_OFS:    st_d.rdata = {14'h0, {(8 - NCH){1'b0}}, ch_lim_act, 1'b0,
                                   st_q.pg, st_q.latched, s_open, st_q.nb_st, st_q.core_st};
        ATTEMPT_OFS: st_d.rdata = {24'h0, 1'b0, st_q.nb_att, 1'b0, st_q.core_att};
        default:     st_d.rdata = 32'h0;
      endcase
    end

    // core rail
    case (st_q.core_st)
      OFS_OFF: begin
        if (en && !st_q.latched) begin
          st_d.core_st = OFS_SOFT;
        end
      end
      OFS_SOFT: begin
        if (core_trip) begin
          st_d.core_st = OFS_WAIT;
          st_d.core_att = st_q.core_att + 3'h1;
          st_d.core_wait = '0;
        end else if (s_ss_done) begin
          st_d.core_st = OFS_RUN;
          st_d.core_att = ATTEMPT_RST;
        end
      end
      OFS_RUN: begin
        if (core_trip) begin
          st_d.core_st = OFS_WAIT;
          st_d.core_att = st_q.core_att + 3'h1;
          st_d.core_wait = '0;
          st_d.psi = 1'b1;
        end
      end
      OFS_WAIT: begin
        if (st_q.core_att >= 3'(MAX_ATTEMPTS)) begin
          st_d.core_st = OFS_LATCHED;
        end else if (st_q.core_wait >= RETRY_WAIT_CNT - 1) begin
          st_d.core_st = en ? OFS_SOFT : OFS_OFF;
        end else begin
          st_d.core_wait = st_q.core_wait + 32'h1;
        end
      end
      OFS_LATCHED: st_d.core_st = OFS_LATCHED;
      OFS_OPEN: begin
        if (!s_open) begin
          st_d.core_st = OFS_OFF;
        end
      end
      default: st_d.core_st = OFS_OFF;
    endcase

    // north-bridge rail
    case (st_q.nb_st)
      OFS_OFF: begin
        if (en && nb_en && !st_q.latched && st_q.core_st != OFS_OPEN) begin
          st_d.nb_st = OFS_SOFT;
        end
      end
      OFS_SOFT: begin
        if (nb_trip) begin
          st_d.nb_st = OFS_WAIT;
          st_d.nb_att = st_q.nb_att + 3'h1;
          st_d.nb_wait = '0;
        end else if (s_nb_ss_done) begin
          st_d.nb_st = OFS_RUN;
          st_d.nb_att = ATTEMPT_RST;
        end
      end
      OFS_RUN: begin
        if (nb_trip) begin
          st_d.nb_st = OFS_WAIT;
          st_d.nb_att = st_q.nb_att + 3'h1;
          st_d.nb_wait = '0;
        end
      end
      OFS_WAIT: begin
        if (st_q.nb_att >= 3'(MAX_ATTEMPTS)) begin
          st_d.nb_st = OFS_LATCHED;
        end else if (st_q.nb_wait >= RETRY_WAIT_CNT - 1) begin
          st_d.nb_st = (en && nb_en) ? OFS_SOFT : OFS_OFF;
        end else begin
          st_d.nb_wait = st_q.nb_wait + 32'h1;
        end
      end
      OFS_LATCHED: st_d.nb_st = OFS_LATCHED;
      default:     st_d.nb_st = OFS_OFF;
    endcase

    if (st_d.core_st == OFS_LATCHED || st_d.nb_st == OFS_LATCHED) begin
      st_d.latched = 1'b1;
      st_d.core_st = OFS_LATCHED;
      st_d.nb_st   = OFS_LATCHED;
    end else if (s_open) begin
      st_d.core_st = OFS_OPEN;
      st_d.nb_st   = OFS_OFF;
    end else if (!en) begin
      st_d.core_st = (st_d.core_st == OFS_OPEN) ? OFS_OPEN : OFS_OFF;
      st_d.nb_st   = OFS_OFF;
    end

    if (st_q.core_st == OFS_RUN && st_d.core_st == OFS_RUN && !st_q.ctrl[CTRL_PSI_BIT]) begin
      st_d.psi = 1'b0;
    end

    st_d.pg = (st_d.core_st == OFS_RUN) && s_vok &&
              (!nb_en || st_d.nb_st == OFS_RUN);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q         <= '0;
      st_q.core_st <= OFS_OFF;
      st_q.nb_st   <= OFS_OFF;
      st_q.ctrl    <= CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // =========================================================================
  // outputs
  assign core_on = (st_q.core_st == OFS_SOFT) || (st_q.core_st == OFS_RUN);
  assign nb_on   = (st_q.nb_st == OFS_SOFT) || (st_q.nb_st == OFS_RUN);

  // gates low and phases floated off
  // phases three and four float whenever the core rail is off; the indicator gates no phase
  assign upper_gate_drive   = core_on ? ch_upper[1:0] : 2'h0;
  assign lower_gate_drive   = core_on ? ch_lower[1:0] : 2'h0;
  assign nb_upper_gate_drive = nb_on & nb_upper_req;
  assign nb_lower_gate_drive = nb_on & nb_lower_req;
  assign external_phase_three_drive = ch_upper[2 % NCH];
  assign external_phase_four_drive  = ch_upper[3 % NCH];
  assign external_phase_three_oe_b  = ~core_on;
  assign external_phase_four_oe_b   = ~core_on;
  assign power_good_out       = st_q.pg;
  assign power_save_indicator = st_q.psi;
  assign core_soft_start_req  = (st_q.core_st == OFS_SOFT);
  assign nb_soft_start_req    = (st_q.nb_st == OFS_SOFT);
  assign prdata  = st_q.rdata;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // =========================================================================
  // checks
  sequence s_core_trip;
    st_q.core_st == OFS_RUN && core_trip;
  endsequence

  AST_OPEN_SHUT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_open && !st_q.latched |=> st_q.core_st == OFS_OPEN)
    else $error("open sense did not shut down");
  AST_OPEN_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_q.core_st == OFS_OPEN && !s_open && en |=> ##1 st_q.core_st == OFS_SOFT)
    else $error("no restart after open cleared");
  AST_NOM_TRIP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_core_trip |=> st_q.core_st != OFS_RUN)
    else $error("nominal trip ignored");
  AST_BOOST: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_q.core_st == OFS_SOFT && !s_core_bst && !s_open && en |=> st_q.core_st != OFS_WAIT)
    else $error("soft-start tripped below boosted level");
  AST_GATES_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_q.core_st == OFS_WAIT |-> upper_gate_drive == 2'h0 && lower_gate_drive == 2'h0
    && external_phase_three_oe_b && !power_good_out)
    else $error("gates active during shutdown");
  AST_CNT_MAX: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_q.core_att <= 3'(MAX_ATTEMPTS))
    else $error("attempt counter overrun");
  AST_LATCH: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_q.latched |=> st_q.latched && !nb_upper_gate_drive && upper_gate_drive == 2'h0)
    else $error("latch released");
  AST_CLR_CNT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_q.core_st == OFS_SOFT ##1 st_q.core_st == OFS_RUN |-> st_q.core_att == ATTEMPT_RST)
    else $error("counter not cleared");
  AST_NB_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_q.nb_st == OFS_WAIT && !st_q.latched |-> !nb_upper_gate_drive && !nb_lower_gate_drive)
    else $error("nb gates active in shutdown");
  AST_CH_LIM: assert property (@(posedge clk_sys) disable iff (!rst_b)
    core_on && s_chan[0] |-> !upper_gate_drive[0] && lower_gate_drive[0])
    else $error("channel limit not applied");
  AST_PG: assert property (@(posedge clk_sys) disable iff (!rst_b)
    power_good_out |-> $past(st_q.core_st) == OFS_RUN || st_q.core_st == OFS_RUN)
    else $error("power good outside run");

endmodule // ofs_top

//--- tb/ofs_stage_model.sv
// behavioural power stages: output ramps and injected overcurrent
`timescale 1ns/10ps
module ofs_stage_model #(
  parameter int unsigned RAMP = 8
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       core_soft_start_req,
  input  wire logic       nb_soft_start_req,
  input  wire logic [1:0] upper_gate_drive,
  input  wire logic [1:0] lower_gate_drive,
  input  wire logic       nb_upper_gate_drive,
  input  wire logic       nb_lower_gate_drive,
  input  wire logic [1:0] core_fault,
  input  wire logic [1:0] nb_fault,
  output logic            soft_start_done,
  output logic            nb_soft_start_done,
  output logic            volts_in_limits,
  output logic            core_avg_over_nom,
  output logic            core_avg_over_boost,
  output logic            nb_avg_over_nom,
  output logic            nb_avg_over_boost
);
  // ==========================================================================
  // output ramps
  logic [7:0] core_lvl_q;
  logic [7:0] nb_lvl_q;
  logic       core_off;
  logic       nb_off;

  // every gate off with no soft-start request discharges the output, so a stale done never leaks into a retry
  assign core_off = !core_soft_start_req && (upper_gate_drive | lower_gate_drive) == 2'b00;
  assign nb_off   = !nb_soft_start_req && !nb_upper_gate_drive && !nb_lower_gate_drive;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      core_lvl_q <= 8'h00;
      nb_lvl_q   <= 8'h00;
    end else begin
      if (core_off) begin
        core_lvl_q <= 8'h00;
      end else if (core_soft_start_req && core_lvl_q < 8'(RAMP)) begin
        core_lvl_q <= core_lvl_q + 8'h01;
      end
      if (nb_off) begin
        nb_lvl_q <= 8'h00;
      end else if (nb_soft_start_req && nb_lvl_q < 8'(RAMP)) begin
        nb_lvl_q <= nb_lvl_q + 8'h01;
      end
    end
  end

  // ==========================================================================
  // flags; fault current flows only while the output is up
  assign soft_start_done     = core_lvl_q == 8'(RAMP);
  assign nb_soft_start_done  = nb_lvl_q == 8'(RAMP);
  assign volts_in_limits     = soft_start_done;
  assign core_avg_over_nom   = core_fault != 2'b00 && core_lvl_q != 8'h00;
  assign core_avg_over_boost = core_fault[1] && core_lvl_q != 8'h00;
  assign nb_avg_over_nom     = nb_fault != 2'b00 && nb_lvl_q != 8'h00;
  assign nb_avg_over_boost   = nb_fault[1] && nb_lvl_q != 8'h00;
endmodule // ofs_stage_model

//--- tb/ofs_top_tb.sv
// self-checking testbench for the overcurrent fault sequencer
`timescale 1ns/10ps
module ofs_top_tb
  import ofs_pkg::*;
;
  // ==========================================================================
  // signals and instances
  localparam int unsigned WAIT_N = 20;
  logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, sense_open;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        core_avg_over_nom, core_avg_over_boost, nb_avg_over_nom, nb_avg_over_boost;
  logic        soft_start_done, nb_soft_start_done, volts_in_limits;
  logic [3:0]  chan_over_limit, pwm_upper_req, pwm_lower_req;
  logic        nb_upper_req, nb_lower_req, nb_upper_gate_drive, nb_lower_gate_drive;
  logic [1:0]  upper_gate_drive, lower_gate_drive, core_fault, nb_fault;
  logic        external_phase_three_drive, external_phase_three_oe_b;
  logic        external_phase_four_drive, external_phase_four_oe_b;
  logic        power_good_out, power_save_indicator, core_soft_start_req, nb_soft_start_req;
  int          err_total, checks_done;

  ofs_top #(.NCH(4), .RETRY_WAIT_CNT(WAIT_N)) ofs_top_inst (
    .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sense_open, .core_avg_over_nom, .core_avg_over_boost, .nb_avg_over_nom,
    .nb_avg_over_boost, .chan_over_limit, .soft_start_done, .nb_soft_start_done,
    .volts_in_limits, .pwm_upper_req, .pwm_lower_req, .nb_upper_req, .nb_lower_req,
    .upper_gate_drive, .lower_gate_drive, .nb_upper_gate_drive, .nb_lower_gate_drive,
    .external_phase_three_drive, .external_phase_three_oe_b, .external_phase_four_drive,
    .external_phase_four_oe_b, .power_good_out, .power_save_indicator,
    .core_soft_start_req, .nb_soft_start_req
  );

  ofs_stage_model ofs_stage_model_inst (
    .clk_sys, .rst_b, .core_soft_start_req, .nb_soft_start_req, .upper_gate_drive,
    .lower_gate_drive, .nb_upper_gate_drive, .nb_lower_gate_drive, .core_fault, .nb_fault,
    .soft_start_done, .nb_soft_start_done, .volts_in_limits, .core_avg_over_nom,
    .core_avg_over_boost, .nb_avg_over_nom, .nb_avg_over_boost
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one transfer plus an idle cycle, so back-to-back calls never retoggle psel in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    if (pready !== 1'b1) err_total++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wait_st(input string what, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      apb(1'b0, STAT_OFS, 32'h0, s);
      n++;
    end while ((s & m) !== v && n < 400);
    chk(what, s & m, v);
  endtask

  task automatic do_reset;
    rst_b <= 1'b0;
    tick(20);
    rst_b <= 1'b1;
    tick(1);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] q;
    chk("gates", 32'({upper_gate_drive, lower_gate_drive, nb_lower_gate_drive}), 32'h0);
    chk("float", 32'({external_phase_three_oe_b, external_phase_four_oe_b}), 32'h3);
    chk("pg", 32'(power_good_out), 32'h0);
    chk("resp", 32'({pready, pslverr}), 32'h2);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF, q);
    apb(1'b0, 8'h0C, 32'h0, q);
    chk("unmapped", q, 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0, q);
    chk("ctrl", q, 32'h0);
    $display("done: reset");
  endtask

  task automatic t_start;
    logic [31:0] q;
    apb(1'b1, CTRL_OFS, 32'h1, q);
    tick(1);
    chk("ramp req", 32'(core_soft_start_req), 32'h1);
    chk("pg soft", 32'(power_good_out), 32'h0);
    wait_st("run", 32'h7, 32'(OFS_RUN));
    tick(8);
    chk("pg run", 32'(power_good_out), 32'h1);
    apb(1'b0, ATTEMPT_OFS, 32'h0, q);
    chk("attempts", q & 32'h7, 32'h0);
    $display("done: start");
  endtask

  task automatic t_limit;
    logic [31:0] q;
    pwm_upper_req   <= 4'hF;
    pwm_lower_req   <= 4'h0;
    chan_over_limit <= 4'b0101;
    tick(2);
    chk("sync", 32'(upper_gate_drive), 32'h3);
    tick(24);
    chk("upper", 32'(upper_gate_drive), 32'h2);
    chk("lower", 32'(lower_gate_drive), 32'h1);
    chk("ext", 32'({external_phase_three_drive, external_phase_four_drive}), 32'h1);
    chk("pg", 32'(power_good_out), 32'h1);
    apb(1'b0, STAT_OFS, 32'h0, q);
    chk("lim flags", (q >> 10) & 32'hF, 32'h5);
    chan_over_limit <= 4'h0;
    tick(6);
    chk("release", 32'(upper_gate_drive), 32'h3);
    pwm_upper_req   <= 4'h0;
    pwm_lower_req   <= 4'hF;
    $display("done: limit");
  endtask

  task automatic t_open;
    sense_open <= 1'b1;
    wait_st("open", 32'h7, 32'(OFS_OPEN));
    chk("gates", 32'({upper_gate_drive, lower_gate_drive, power_good_out}), 32'h0);
    tick(40);
    wait_st("held", 32'h7, 32'(OFS_OPEN));
    sense_open <= 1'b0;
    wait_st("restart", 32'h7, 32'(OFS_RUN));
    $display("done: open");
  endtask

  task automatic t_hiccup;
    logic [31:0] q;
    apb(1'b1, CTRL_OFS, 32'h5, q);
    core_fault <= 2'h1;
    for (int i = 0; i < 9; i++) begin
      wait_st("trip", 32'h7, 32'(OFS_WAIT));
      chk("off", 32'({upper_gate_drive, lower_gate_drive, power_good_out}), 32'h0);
      chk("float", 32'({external_phase_three_oe_b, external_phase_four_oe_b}), 32'h3);
      chk("psave", 32'(power_save_indicator), 32'h1);
      apb(1'b0, ATTEMPT_OFS, 32'h0, q);
      chk("count", q & 32'h7, 32'h1);
      wait_st("retry", 32'h7, 32'(OFS_SOFT));
    end
    wait_st("unlatched", 32'h80, 32'h0);
    core_fault <= 2'h0;
    apb(1'b1, CTRL_OFS, 32'h1, q);
    $display("done: hiccup");
  endtask

  task automatic t_cancel;
    logic [31:0] q;
    core_fault <= 2'h2;
    wait_st("trip", 32'h7, 32'(OFS_WAIT));
    apb(1'b1, CTRL_OFS, 32'h0, q);
    tick(WAIT_N + 20);
    chk("no ramp", 32'(core_soft_start_req), 32'h0);
    apb(1'b0, STAT_OFS, 32'h0, q);
    chk("no retry", 32'(q[2:0] == OFS_SOFT), 32'h0);
    $display("done: cancel");
  endtask

  task automatic t_latch;
    logic [31:0] q;
    core_fault <= 2'h2;
    do_reset;
    apb(1'b1, CTRL_OFS, 32'h3, q);
    tick(1);
    chk("both ramp", 32'({core_soft_start_req, nb_soft_start_req}), 32'h3);
    for (int k = 1; k < 7; k++) begin
      wait_st("trip", 32'h7, 32'(OFS_WAIT));
      apb(1'b0, ATTEMPT_OFS, 32'h0, q);
      chk("count", q & 32'h7, 32'(k));
      wait_st("retry", 32'h7, 32'(OFS_SOFT));
    end
    wait_st("latched", 32'h87, 32'h80 | 32'(OFS_LATCHED));
    chk("both off", 32'({upper_gate_drive, lower_gate_drive, nb_lower_gate_drive}), 32'h0);
    core_fault <= 2'h0;
    apb(1'b1, CTRL_OFS, 32'h0, q);
    apb(1'b1, CTRL_OFS, 32'h3, q);
    tick(60);
    wait_st("still", 32'h80, 32'h80);
    do_reset;
    wait_st("cleared", 32'h80, 32'h0);
    apb(1'b0, ATTEMPT_OFS, 32'h0, q);
    chk("count clr", q & 32'h77, 32'h0);
    $display("done: latch");
  endtask

  task automatic t_nb;
    logic [31:0] q;
    apb(1'b1, CTRL_OFS, 32'h1, q);
    wait_st("run", 32'h7, 32'(OFS_RUN));
    nb_fault <= 2'h2;
    nb_upper_req <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h3, q);
    wait_st("nb trip", 32'h3F, (32'(OFS_WAIT) << 3) | 32'(OFS_RUN));
    chk("core on", 32'({lower_gate_drive, nb_lower_gate_drive, nb_upper_gate_drive}), 32'hC);
    wait_st("latched", 32'h80, 32'h80);
    chk("both off", 32'({lower_gate_drive, nb_lower_gate_drive}), 32'h0);
    $display("done: north bridge");
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    {rst_b, psel, penable, pwrite, sense_open, nb_upper_req} = 6'h00;
    nb_lower_req    = 1'b1;
    paddr           = 8'h00;
    pwdata          = 32'h0;
    chan_over_limit = 4'h0;
    pwm_upper_req   = 4'h0;
    pwm_lower_req   = 4'hF;
    core_fault      = 2'h0;
    nb_fault        = 2'h0;
    err_total       = 0;
    checks_done     = 0;
    tick(20);
    rst_b <= 1'b1;
    tick(1);
    t_reset;
    t_start;
    t_limit;
    t_open;
    t_hiccup;
    t_cancel;
    t_latch;
    t_nb;
    give_verdict;
  end

  // the whole run needs about a thousand cycles; fifty thousand means a hang
  initial begin
    #500_000;
    err_total++;
    $display("[FAIL] watchdog expected finish seen hang");
    give_verdict;
  end
endmodule // ofs_top_tb
